// >>> bench/chip_select_range_decoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module chip_select_range_decoder_asserts (
  input wire logic                                   clk,
  input wire logic                                   rst,
  input wire logic                                   clk_en,
  input wire chip_select_range_decoder_pkg::wb_req_t    wb_req,
  input wire chip_select_range_decoder_pkg::wb_rsp_t    wb_rsp,
  input wire chip_select_range_decoder_pkg::bus_cycle_t bus_cycle,
  input wire logic                                   chip_select_0_n,
  input wire logic                                   chip_select_1_n,
  input wire logic                                   chip_select_2_n,
  input wire logic                                   chip_select_3_n
);
  import chip_select_range_decoder_pkg::*;
  // Selects as active-high bits, request and decode helpers
  wire [3:0] low = ~{chip_select_3_n, chip_select_2_n,
                     chip_select_1_n, chip_select_0_n};
  wire req = wb_req.cyc && wb_req.stb;
  wire mapped = wb_req.adr >= 32'hFFFF_E400 && wb_req.adr <= 32'hFFFF_E414;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held longer than one cycle");
  a_ack_follows: assert property (req && !wb_rsp.ack && clk_en |=> wb_rsp.ack)
    else $error("request not answered next cycle");
  a_no_stray_ack: assert property (!req |=> !wb_rsp.ack)
    else $error("ack without request");
  a_one_select: assert property ($onehot0(low))
    else $error("more than one select low");
  a_idle_high: assert property (!bus_cycle.valid && clk_en |=> low == 4'h0)
    else $error("select low without bus cycle");
  a_needs_cycle: assert property (low != 4'h0 |-> $past(bus_cycle.valid))
    else $error("select not from previous cycle");
  a_read_hold: assert property (!wb_rsp.ack |-> $stable(wb_rsp.dat))
    else $error("read data changed without ack");
  a_unmapped_zero: assert property (wb_rsp.ack && !wb_req.we && !mapped
    |-> wb_rsp.dat == 32'h0)
    else $error("unmapped read not zero");
  a_hold_frozen: assert property (!clk_en |=> $stable(low) && $stable(wb_rsp))
    else $error("state moved while clock enable low");
  c_write: cover property (wb_rsp.ack && wb_req.we);
  c_read: cover property (wb_rsp.ack && !wb_req.we);
  c_high_sel: cover property (low[2]);
endmodule // chip_select_range_decoder_asserts
bind chip_select_range_decoder chip_select_range_decoder_asserts
  chip_select_range_decoder_asserts_inst (.clk(clk), .rst(rst),
  .clk_en(clk_en), .wb_req(wb_req), .wb_rsp(wb_rsp), .bus_cycle(bus_cycle),
  .chip_select_0_n(chip_select_0_n), .chip_select_1_n(chip_select_1_n),
  .chip_select_2_n(chip_select_2_n), .chip_select_3_n(chip_select_3_n));
`default_nettype wire

// >>> bench/csd_devices.sv
`timescale 1ns/1ps
`default_nettype none
// External memory and I/O parts, reporting which one is selected
module csd_devices (
  input  wire logic       chip_select_0_n,
  input  wire logic       chip_select_1_n,
  input  wire logic       chip_select_2_n,
  input  wire logic       chip_select_3_n,
  output var  logic [2:0] hit
);
  // Index of the selected part, 4 when none is selected
  always_comb begin
    if (!chip_select_0_n) hit = 3'h0;
    else if (!chip_select_1_n) hit = 3'h1;
    else if (!chip_select_2_n) hit = 3'h2;
    else if (!chip_select_3_n) hit = 3'h3;
    else hit = 3'h4;
  end
endmodule // csd_devices
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import chip_select_range_decoder_pkg::*;
  logic        clk = 0, rst = 1, clk_en = 1, seen = 0;
  wb_req_t     req = '0;
  wb_rsp_t     rsp;
  bus_cycle_t  bc = '0;
  logic [3:0]  cs_n;
  logic [2:0]  hit;
  logic [31:0] rdq[$];
  logic [2:0]  csq[$];
  int          n_errors = 0, tests_run = 0, cycles = 0, seed = 36, i;
  // Reset values, then probe address and expected part
  logic [31:0] rv[5] = '{32'h3FF, 32'h3FF, 32'h1FF, 32'h1FF, 32'h1};
  logic [34:0] pt[16] = '{{32'hC000_0000, 3'h0}, {32'hC000_FFFF, 3'h0},
    {32'hC001_0000, 3'h4}, {32'h8000_0000, 3'h4}, {32'h0200_0000, 3'h1},
    {32'h02FF_FFFF, 3'h1}, {32'h0300_0000, 3'h4}, {32'h1FD0_0000, 3'h4},
    {32'h1FD0_0000, 3'h2}, {32'h1FDF_FFFF, 3'h2}, {32'h1FE0_0000, 3'h4},
    {32'h9FD0_0000, 3'h4}, {32'h2000_8000, 3'h3}, {32'h20FF_FFFF, 3'h3},
    {32'h2100_0000, 3'h4}, {32'h0000_0000, 3'h4}};
  always #2.5 clk = ~clk;
  chip_select_range_decoder chip_select_range_decoder_inst (.clk(clk),
    .rst(rst), .clk_en(clk_en), .wb_req(req), .wb_rsp(rsp), .bus_cycle(bc),
    .chip_select_0_n(cs_n[0]), .chip_select_1_n(cs_n[1]),
    .chip_select_2_n(cs_n[2]), .chip_select_3_n(cs_n[3]));
  csd_devices csd_devices_inst (.chip_select_0_n(cs_n[0]),
    .chip_select_1_n(cs_n[1]), .chip_select_2_n(cs_n[2]),
    .chip_select_3_n(cs_n[3]), .hit(hit));
  // Compare read data and selected part
  task chk_rd(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] read data exp %h got %h", exp, got);
    end
  endtask
  task chk_cs(input logic [2:0] exp, input logic [2:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] selected part exp %0d got %0d", exp, got);
    end
  endtask
  task conclude;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One Wishbone cycle; for a read d is the expected word
  task wb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    req <= '{1'b1, 1'b1, w, a, s, d};
    if (!w) rdq.push_back(d);
    @(posedge clk);
    while (rsp.ack !== 1'b1) @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  // Present one address for a single cycle
  task probe(input logic [31:0] a, input logic [2:0] e);
    bc <= '{1'b1, a};
    csq.push_back(e);
    @(posedge clk);
  endtask
  // Watcher takes the oldest note when a result appears
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 3000) begin
      n_errors++;
      conclude;
    end
    if (seen) chk_cs(csq.pop_front(), hit);
    seen <= bc.valid;
    if (rsp.ack && req.cyc && !req.we) chk_rd(rdq.pop_front(), rsp.dat);
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 5; i++) wb(0, 32'hFFFF_E400 + 4 * i, rv[i], 4'hF);
    wb(1, 32'hFFFF_E418, 32'hFFFF_FFFF, 4'hF);
    wb(0, 32'hFFFF_E418, 32'h0, 4'hF);
    wb(1, 32'hFFFF_E400, 32'hC000_0003, 4'hF);
    wb(1, 32'hFFFF_E404, 32'h0200_FFFF, 4'hC);
    wb(0, 32'hFFFF_E404, 32'h0200_03FF, 4'hF);
    wb(1, 32'hFFFF_E408, 32'h1FD0_001F, 4'hF);
    wb(1, 32'hFFFF_E40C, 32'h2000_01FF, 4'hF);
    for (i = 0; i < 16; i++) begin
      // Park the bus cycle so no select result is noted during the write
      if (i == 8) begin
        bc.valid <= 1'b0;
        wb(1, 32'hFFFF_E410, 32'h3, 4'hF);
      end
      probe(pt[i][34:3], pt[i][2:0]);
    end
    repeat (8) probe(32'hC000_0000 | ($random(seed) & 32'hFFFF), 3'h0);
    // Frozen clock enable keeps the last select although the address moves
    clk_en <= 1'b0;
    probe(32'h0000_0000, 3'h0);
    clk_en <= 1'b1;
    bc <= '{1'b0, 32'h5A5A_A5A5};
    repeat (3) @(posedge clk);
    conclude;
  end
endmodule // testbench
`default_nettype wire

// >>> verilog/chip_select_range_decoder.sv
// Function
// - Four windows, each drives its chip select
// - Select active only inside programmed window
// - Base bits 31:16, mask bits 15:0, RW
// - Base compared with address bits 31:16
// - Window start low sixteen bits zero
// - Set mask bit drops that bit
// - Match when all unmasked bits equal
// - Compare afresh on every bus cycle
// - Windows 0,1 mask covers A29..A14
// - Windows 2,3 mask covers A30..A15
// - Windows 0,1 span 16K to 16M
// - External space limited to sixteen megabytes
// - Windows 0,1 always compare A31,A30
// - Windows 2,3 always compare A31
// - Pair enable bit gates its selects
`timescale 1ns/1ps
`default_nettype none
`include "chip_select_range_decoder_cfg.svh"

module chip_select_range_decoder (
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire logic                                clk_en,
  input  wire chip_select_range_decoder_pkg::wb_req_t    wb_req,
  output var  chip_select_range_decoder_pkg::wb_rsp_t    wb_rsp,
  input  wire chip_select_range_decoder_pkg::bus_cycle_t bus_cycle,
  output var  logic                                chip_select_0_n,
  output var  logic                                chip_select_1_n,
  output var  logic                                chip_select_2_n,
  output var  logic                                chip_select_3_n
);
  import chip_select_range_decoder_pkg::*;

  localparam int N_WIN = 4;

  // Window registers, base in the upper half, mask in the lower
  logic [31:0]      window_register [N_WIN];
  // Pair enables: bit 0 windows 0 and 1, bit 1 windows 2 and 3
  logic [1:0]       pair_enable;
  // Registered chip selects, active low
  logic [N_WIN-1:0] cs_n;
  // Registered Wishbone answer
  logic             ack;
  logic [31:0]      rd_data;

  // Raw window hits for the current address
  wire  [N_WIN-1:0] window_hit;
  // Hits gated by their pair enable
  wire  [N_WIN-1:0] enabled_hit;
  // One-hot winner after priority
  wire  [N_WIN-1:0] winner;
  // Next chip select vector, active low
  wire  [N_WIN-1:0] next_cs_n;

  // Wishbone access qualifiers
  wire              wb_access;
  wire              wb_start;
  wire              wb_commit;
  wire reg_sel_t    reg_sel;
  wire  [31:0]      read_mux;
  wire  [31:0]      write_merge;
  wire  [31:0]      status_word;

  // Merge write data into a word under the byte lanes
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Compare one address against one window register
  function automatic logic window_match(
    input logic [31:0] addr,
    input logic [31:0] win,
    input logic        high_pair
  );
    logic [31:0] base_full;
    logic [15:0] eff_mask;
    logic [31:0] mask_pos;
    logic [31:0] care;
    // Start address, low half always zero
    base_full = {win[`CSD_BASE_MSB:`CSD_BASE_LSB], 16'h0000};
    if (high_pair) begin
      // Mask bits above A23 never take effect
      eff_mask = {7'h00, win[`CSD_HIGH_PAIR_MW-1:`CSD_MASK_LSB]};
      // Mask sits on A30..A15, A31 always compared
      mask_pos = {1'b0, eff_mask, 15'h0000};
      care     = ~(mask_pos | 32'h0000_7FFF);
    end else begin
      // Mask bits above A23 never take effect
      eff_mask = {6'h00, win[`CSD_LOW_PAIR_MW-1:`CSD_MASK_LSB]};
      // Mask sits on A29..A14, A31 and A30 always compared
      mask_pos = {2'b00, eff_mask, 14'h0000};
      care     = ~(mask_pos | 32'h0000_3FFF);
    end
    // Only unmasked bits must equal the base
    return ((addr ^ base_full) & care) == 32'h0000_0000;
  endfunction

  // Address decode of the register map
  function automatic reg_sel_t decode_addr(input logic [31:0] adr);
    reg_sel_t s;
    if (adr == `CSD_WIN0_ADDR) begin
      s = SEL_WIN0;
    end else if (adr == `CSD_WIN1_ADDR) begin
      s = SEL_WIN1;
    end else if (adr == `CSD_WIN2_ADDR) begin
      s = SEL_WIN2;
    end else if (adr == `CSD_WIN3_ADDR) begin
      s = SEL_WIN3;
    end else if (adr == `CSD_CTRL_ADDR) begin
      s = SEL_CTRL;
    end else if (adr == `CSD_STAT_ADDR) begin
      s = SEL_STAT;
    end else begin
      s = SEL_NONE;
    end
    return s;
  endfunction

  // Per-window comparators and enable gating
  generate
    for (genvar i = 0; i < N_WIN; i++) begin : g_win
      // Windows 2 and 3 use the upper mask mapping
      assign window_hit[i] =
        window_match(bus_cycle.addr, window_register[i], i >= 2);
      // Each pair answers only while its enable is set
      assign enabled_hit[i] = window_hit[i] & pair_enable[i/2];
    end
  endgenerate

  // Lowest window wins so only one device drives the bus
  assign winner      = enabled_hit & (~enabled_hit + 4'h1);
  // Idle bus or no enabled hit leaves every select high
  assign next_cs_n   = bus_cycle.valid ? ~winner : 4'hF;

  // Wishbone request phases
  assign wb_access   = wb_req.cyc & wb_req.stb;
  // First cycle of a request, answer not yet given
  assign wb_start    = wb_access & ~ack;
  // Edge at which the master samples ack: write lands here
  assign wb_commit   = wb_access & ack & wb_req.we;
  assign reg_sel     = decode_addr(wb_req.adr);

  // Live chip select state as seen by software
  assign status_word = {28'h000_0000, ~cs_n};

  // Read selection, unmapped space reads zero
  assign read_mux =
    (reg_sel == SEL_WIN0) ? window_register[0] :
    (reg_sel == SEL_WIN1) ? window_register[1] :
    (reg_sel == SEL_WIN2) ? window_register[2] :
    (reg_sel == SEL_WIN3) ? window_register[3] :
    (reg_sel == SEL_CTRL) ? {30'h0000_0000, pair_enable} :
    (reg_sel == SEL_STAT) ? status_word :
    32'h0000_0000;

  // Byte-lane merge against the addressed register
  assign write_merge = lane_merge(read_mux, wb_req.dat, wb_req.sel);

  // Window register storage and writes
  generate
    for (genvar i = 0; i < N_WIN; i++) begin : g_reg
      // Per-window reset value
      localparam logic [31:0] RST_VAL =
        (i == 0) ? `CSD_WIN0_RST :
        (i == 1) ? `CSD_WIN1_RST :
        (i == 2) ? `CSD_WIN2_RST : `CSD_WIN3_RST;
      // Full-width read and write of base and mask
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          window_register[i] <= RST_VAL;
        end else if (clk_en && wb_commit &&
                     reg_sel == reg_sel_t'(i)) begin
          window_register[i] <= write_merge;
        end
      end
    end
  endgenerate

  // Pair enable register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pair_enable <= `CSD_CTRL_RST;
    end else if (clk_en && wb_commit && reg_sel == SEL_CTRL) begin
      // Only the two enable bits are stored
      pair_enable <= write_merge[`CSD_CTRL_HIGH_BIT:`CSD_CTRL_LOW_BIT];
    end
  end

  // Wishbone answer: ack one cycle after the request opens
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack     <= 1'b0;
      rd_data <= 32'h0000_0000;
    end else if (clk_en) begin
      // Ack rises once, then drops the cycle after
      ack <= wb_start;
      if (wb_start) begin
        // Read data captured with the ack
        rd_data <= read_mux;
      end
    end
  end

  // Chip selects, recomputed from the address each cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_n <= 4'hF;
    end else if (clk_en) begin
      cs_n <= next_cs_n;
    end
  end

  // Outputs
  assign wb_rsp.ack      = ack;
  assign wb_rsp.dat      = rd_data;
  assign chip_select_0_n = cs_n[0];
  assign chip_select_1_n = cs_n[1];
  assign chip_select_2_n = cs_n[2];
  assign chip_select_3_n = cs_n[3];

endmodule // chip_select_range_decoder

`default_nettype wire

// >>> verilog/chip_select_range_decoder_cfg.svh
`ifndef CHIP_SELECT_RANGE_DECODER_CFG_SVH
`define CHIP_SELECT_RANGE_DECODER_CFG_SVH

// Byte addresses of the window registers
`define CSD_WIN0_ADDR     32'hFFFF_E400
`define CSD_WIN1_ADDR     32'hFFFF_E404
`define CSD_WIN2_ADDR     32'hFFFF_E408
`define CSD_WIN3_ADDR     32'hFFFF_E40C
// Pair enable register and chip select status register
`define CSD_CTRL_ADDR     32'hFFFF_E410
`define CSD_STAT_ADDR     32'hFFFF_E414

// Reset values of the window registers
`define CSD_WIN0_RST      32'h0000_03FF
`define CSD_WIN1_RST      32'h0000_03FF
`define CSD_WIN2_RST      32'h0000_01FF
`define CSD_WIN3_RST      32'h0000_01FF
// Pair enables after reset: low pair on, high pair off
`define CSD_CTRL_RST      2'h1

// Field positions inside a window register
`define CSD_BASE_MSB      31
`define CSD_BASE_LSB      16
`define CSD_MASK_MSB      15
`define CSD_MASK_LSB      0
// Lowest maskable address bit for each pair
`define CSD_LOW_PAIR_SH   14
`define CSD_HIGH_PAIR_SH  15
// Mask bits that stay inside the 16 Mbyte external space
`define CSD_LOW_PAIR_MW   10
`define CSD_HIGH_PAIR_MW  9

// Field positions inside the pair enable register
`define CSD_CTRL_LOW_BIT  0
`define CSD_CTRL_HIGH_BIT 1

`endif

// >>> verilog/chip_select_range_decoder_pkg.sv
`default_nettype none

package chip_select_range_decoder_pkg;

  // Wishbone classic request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  // Wishbone classic answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // Physical address cycle from the processor or DMA
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } bus_cycle_t;

  // Register selected by the Wishbone address
  typedef enum logic [2:0] {
    SEL_WIN0 = 3'b000,
    SEL_WIN1 = 3'b001,
    SEL_WIN2 = 3'b010,
    SEL_WIN3 = 3'b011,
    SEL_CTRL = 3'b100,
    SEL_STAT = 3'b101,
    SEL_NONE = 3'b111
  } reg_sel_t;

endpackage

`default_nettype wire
